/* File: hw/otpbp_pkg.sv */
// Constants, field layout and types shared by the OTP mode and
// bit-program controller. Assumes a 50 MHz system clock.
package otpbp_pkg;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [31:0] ADDR_MODE   = 32'h4000_8000;
  localparam logic [31:0] ADDR_PCTRL  = 32'h4000_8004;
  localparam logic [31:0] ADDR_STAT   = 32'h4000_8008;
  localparam logic [31:0] ADDR_RDWORD = 32'h4000_800c;

  // Reset values and writable-bit masks.
  localparam logic [31:0] MODE_RST   = 32'h0000_0000;
  localparam logic [31:0] PCTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] RDWORD_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_MASK  = 32'h0000_0107;
  localparam logic [31:0] PCTRL_MASK = 32'h0fff_1fff;

  // Field positions.
  localparam int MODE_MSB  = 2;
  localparam int MODE_LSB  = 0;
  localparam int FAST_BIT  = 8;
  localparam int UEN_BIT   = 27;
  localparam int UVAL_BIT  = 26;
  localparam int LEN_BIT   = 25;
  localparam int LVAL_BIT  = 24;
  localparam int USEL_BIT  = 23;
  localparam int UIDX_MSB  = 22;
  localparam int UIDX_LSB  = 20;
  localparam int LSEL_BIT  = 19;
  localparam int LIDX_MSB  = 18;
  localparam int LIDX_LSB  = 16;
  localparam int WADDR_MSB = 12;
  localparam int WADDR_LSB = 0;
  localparam int RDY_BIT   = 1;

  // Operating modes; codes above auto_program are test-only.
  typedef enum logic [2:0] {
    idle_standby = 3'h0,
    manual_read  = 3'h1,
    manual_program = 3'h2,
    auto_read    = 3'h3,
    auto_program = 3'h4
  } otpbp_mode_t;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_READ = 3'h2,
    SEQ_PROG = 3'h4
  } otpbp_seq_t;

  // Cell timing, in ns, and derived cycle counts (rounded up).
  localparam int CLK_MHZ        = 50;
  localparam int PROG_NORMAL_NS = 10000;
  localparam int PROG_FAST_NS   = 2000;
  localparam int READ_NS        = 100;
  localparam int PROG_NORMAL_CYC = (PROG_NORMAL_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_FAST_CYC   = (PROG_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_CYC        = (READ_NS * CLK_MHZ + 999) / 1000;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : otpbp_pkg

/* File: hw/otpbp_timer.sv */
// Down-counter that times one read or program strobe to the cells.
// Assumes load is a one-cycle pulse from the sequencer.
`timescale 1ns/1ps
`default_nettype none
module otpbp_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Control.
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  // Status.
  output logic                  busy,
  output logic                  done
);

  // The done compare needs at least two counter bits.
  if (CNT_W < 2) begin : g_chk_w
    $error("CNT_W must be at least 2");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             done_ff;
  logic             nxt_done;

  // A load restarts the count; done fires once as it reaches zero.
  assign nxt_cnt  = load ? load_val
                  : (cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;
  assign nxt_done = !load && (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
  assign busy     = (cnt_ff != '0);
  assign done     = done_ff;

  // Counter and done flag.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

endmodule : otpbp_timer
`default_nettype wire

/* File: hw/otpbp_ctrl.sv */
// OTP mode select and manual bit-program control, AXI4-Lite slave.
// Assumes two 8-bit cell banks that take a strobe held for the cell
// timing and return 16 read bits each while the read strobe is high.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module otpbp_ctrl
  import otpbp_pkg::*;
#(
  parameter int ADDR_W   = 13,
  parameter int TIMER_W  = 16,
  parameter int PROG_CYC = PROG_NORMAL_CYC,
  parameter int FAST_CYC = PROG_FAST_CYC,
  parameter int RD_CYC   = READ_CYC
) (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // AXI4-Lite write address and data.
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Cell banks: shared address and strobes.
  output logic [ADDR_W-1:0]      mc_addr,
  output logic                   mc_rd_en,
  output logic                   mc_fast,
  // Cell banks: upper bank.
  output logic                   mc_upper_prog,
  output logic                   mc_upper_byte,
  output logic [2:0]             mc_upper_bit,
  output logic                   mc_upper_value,
  input  wire logic [15:0]       mc_upper_rdata,
  // Cell banks: lower bank.
  output logic                   mc_lower_prog,
  output logic                   mc_lower_byte,
  output logic [2:0]             mc_lower_bit,
  output logic                   mc_lower_value,
  input  wire logic [15:0]       mc_lower_rdata
);

  // Refuse settings the address field or timer cannot carry.
  if (ADDR_W != WADDR_MSB - WADDR_LSB + 1) begin : g_chk_addr
    $error("ADDR_W must match the word address field");
  end
  if (PROG_CYC < 1 || FAST_CYC < 1 || RD_CYC < 1
      || PROG_CYC >= (1 << TIMER_W) || RD_CYC >= (1 << TIMER_W)
      || FAST_CYC >= (1 << TIMER_W)) begin : g_chk_time
    $error("Cycle counts must fit the timer and be nonzero");
  end

  // Byte-lane merge, shared by both writable registers.
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_strb

  // True for the two modes that run without software stepping.
  function automatic logic is_auto(input logic [2:0] m);
    return (m == auto_read) || (m == auto_program);
  endfunction : is_auto

  // Register state.
  logic [31:0]       mode_ff;
  logic [31:0]       pctrl_ff;
  logic [31:0]       rdword_ff;
  logic              aw_held_ff;
  logic              w_held_ff;
  logic [31:0]       awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [1:0]        rresp_ff;
  logic [31:0]       rdata_ff;

  // Sequencer and cell-facing state.
  otpbp_seq_t        seq_ff;
  otpbp_seq_t        nxt_seq;
  logic              auto_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic              rd_en_ff;
  logic              uprog_ff;
  logic              lprog_ff;
  logic              ubyte_ff;
  logic              lbyte_ff;
  logic [2:0]        ubit_ff;
  logic [2:0]        lbit_ff;
  logic              uval_ff;
  logic              lval_ff;
  logic              fast_ff;

  // Write path decode.
  wire         do_write  = aw_held_ff && w_held_ff && !bvalid_ff;
  wire         wr_mode   = do_write && (awaddr_ff == ADDR_MODE);
  wire         wr_pctrl  = do_write && (awaddr_ff == ADDR_PCTRL);
  wire         wr_ro     = (awaddr_ff == ADDR_STAT)
                        || (awaddr_ff == ADDR_RDWORD);
  wire         wr_hit    = (awaddr_ff == ADDR_MODE)
                        || (awaddr_ff == ADDR_PCTRL) || wr_ro;
  wire [31:0]  mode_new  = merge_strb(mode_ff, wdata_ff, wstrb_ff)
                        & MODE_MASK;
  wire [31:0]  pctrl_new = merge_strb(pctrl_ff, wdata_ff, wstrb_ff)
                        & PCTRL_MASK;

  // Field views of the stored registers.
  wire [2:0]   cur_mode  = mode_ff[MODE_MSB:MODE_LSB];
  wire [2:0]   new_mode  = mode_new[MODE_MSB:MODE_LSB];
  wire         fast_sel  = mode_ff[FAST_BIT];

  // Sequence launch, from idle only. A manual mode acts on each control write; an
  // automatic mode starts once, on the mode write that selects it.
  // Test codes fall through every compare and so act as standby.
  wire seq_idle   = (seq_ff == SEQ_IDLE);
  wire man_read   = wr_pctrl && (cur_mode == manual_read);
  wire man_prog   = wr_pctrl && (cur_mode == manual_program);
  wire aut_read   = wr_mode && (new_mode == auto_read);
  wire aut_prog   = wr_mode && (new_mode == auto_program);
  wire go_read    = seq_idle && (man_read || aut_read);
  wire go_prog    = seq_idle && (man_prog || aut_prog);
  wire go_auto    = wr_mode && is_auto(new_mode);

  // Control word that the launched sequence uses: a write in the same
  // cycle is taken so the strobe never carries stale fields.
  wire [31:0] pc_use = wr_pctrl ? pctrl_new : pctrl_ff;
  wire        fast_use = wr_mode ? mode_new[FAST_BIT] : fast_sel;

  // Strobe length: fast timing shortens every programming pulse.
  wire [TIMER_W-1:0] prog_len = fast_use
                              ? TIMER_W'(FAST_CYC)
                              : TIMER_W'(PROG_CYC);
  wire [TIMER_W-1:0] load_val = go_read ? TIMER_W'(RD_CYC) : prog_len;
  wire               tmr_load = go_read || go_prog;
  wire               tmr_done;

  // Strobe timer.
  otpbp_timer #(
    .CNT_W    (TIMER_W)
  ) u_timer (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .load     (tmr_load),
    .load_val (load_val),
    .busy     (),
    .done     (tmr_done)
  );

  // Sequencer next state.
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      SEQ_IDLE: begin
        if (go_read) begin
          nxt_seq = SEQ_READ;
        end else if (go_prog) begin
          nxt_seq = SEQ_PROG;
        end
      end
      SEQ_READ, SEQ_PROG: begin
        if (tmr_done) begin
          nxt_seq = SEQ_IDLE;
        end
      end
      default: nxt_seq = SEQ_IDLE;
    endcase
  end

  // The read word packs both banks, upper byte above lower.
  wire [31:0] rd_word = {mc_upper_rdata[15:8], mc_lower_rdata[15:8],
                         mc_upper_rdata[7:0],  mc_lower_rdata[7:0]};
  wire        rd_cap  = (seq_ff == SEQ_READ) && tmr_done;

  // Status: ready drops only for automatic operations.
  wire        auto_rdy = !(auto_ff && !seq_idle);
  wire [31:0] stat_val = {{(31-RDY_BIT){1'b0}}, auto_rdy,
                          {RDY_BIT{1'b0}}};

  // Read path decode.
  wire ar_take = s_axi_arvalid && !rvalid_ff;
  wire [31:0] rd_mux =
      (s_axi_araddr == ADDR_MODE)   ? mode_ff   :
      (s_axi_araddr == ADDR_PCTRL)  ? pctrl_ff  :
      (s_axi_araddr == ADDR_STAT)   ? stat_val  :
      (s_axi_araddr == ADDR_RDWORD) ? rdword_ff : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr == ADDR_MODE)
             || (s_axi_araddr == ADDR_PCTRL)
             || (s_axi_araddr == ADDR_STAT)
             || (s_axi_araddr == ADDR_RDWORD);

  // Bus handshake outputs.
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;

  // Cell-bank outputs, all from flip-flops.
  assign mc_addr        = addr_ff;
  assign mc_rd_en       = rd_en_ff;
  assign mc_fast        = fast_ff;
  assign mc_upper_prog  = uprog_ff;
  assign mc_upper_byte  = ubyte_ff;
  assign mc_upper_bit   = ubit_ff;
  assign mc_upper_value = uval_ff;
  assign mc_lower_prog  = lprog_ff;
  assign mc_lower_byte  = lbyte_ff;
  assign mc_lower_bit   = lbit_ff;
  assign mc_lower_value = lval_ff;

  // Write channel capture; address and data may come in either order.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 32'h0000_0000;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response; read-only targets are accepted and ignored.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read response; an unmapped address answers zero with an error.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Software registers. Mode writes are never refused, even mid
  // sequence: the order of mode changes is left to software.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_ff  <= MODE_RST;
      pctrl_ff <= PCTRL_RST;
    end else begin
      if (wr_mode) begin
        mode_ff <= mode_new;
      end
      if (wr_pctrl) begin
        pctrl_ff <= pctrl_new;
      end
    end
  end

  // Sequencer state, auto marker and captured read word.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      seq_ff    <= SEQ_IDLE;
      auto_ff   <= 1'b0;
      rdword_ff <= RDWORD_RST;
    end else begin
      seq_ff <= nxt_seq;
      if (tmr_load) begin
        auto_ff <= go_auto;
      end
      if (rd_cap) begin
        rdword_ff <= rd_word;
      end
    end
  end

  // Cell address and bit selection, latched at launch and held.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      addr_ff  <= '0;
      ubyte_ff <= 1'b0;
      lbyte_ff <= 1'b0;
      ubit_ff  <= 3'h0;
      lbit_ff  <= 3'h0;
      uval_ff  <= 1'b0;
      lval_ff  <= 1'b0;
      fast_ff  <= 1'b0;
    end else if (tmr_load) begin
      addr_ff  <= pc_use[WADDR_MSB:WADDR_LSB];
      ubyte_ff <= pc_use[USEL_BIT];
      ubit_ff  <= pc_use[UIDX_MSB:UIDX_LSB];
      lbyte_ff <= pc_use[LSEL_BIT];
      lbit_ff  <= pc_use[LIDX_MSB:LIDX_LSB];
      uval_ff  <= pc_use[UVAL_BIT];
      lval_ff  <= pc_use[LVAL_BIT];
      fast_ff  <= fast_use;
    end
  end

  // Strobes stand for the timed length; a disabled bank sees none,
  // so its cells cannot be disturbed by the other bank's pulse.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_en_ff <= 1'b0;
      uprog_ff <= 1'b0;
      lprog_ff <= 1'b0;
    end else if (go_read) begin
      rd_en_ff <= 1'b1;
    end else if (go_prog) begin
      uprog_ff <= pc_use[UEN_BIT];
      lprog_ff <= pc_use[LEN_BIT];
    end else if (tmr_done) begin
      rd_en_ff <= 1'b0;
      uprog_ff <= 1'b0;
      lprog_ff <= 1'b0;
    end
  end

endmodule : otpbp_ctrl
`default_nettype wire

/* File: testbench/otpbp_ctrl_asserts.sv */
// Concurrent checks on the cell-side strobes of the OTP controller.
// Assumes it is bound to otpbp_ctrl and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module otpbp_ctrl_asserts #(
  parameter int ADDR_W   = 13,
  parameter int PROG_CYC = 500,
  parameter int FAST_CYC = 100,
  parameter int RD_CYC   = 5
) (
  // Clock and reset.
  input wire logic              sys_clk,
  input wire logic              reset_n,
  // Bus answers.
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_rvalid,
  // Cell strobes and fields.
  input wire logic [ADDR_W-1:0] mc_addr,
  input wire logic              mc_rd_en,
  input wire logic              mc_fast,
  input wire logic              mc_upper_prog,
  input wire logic              mc_upper_byte,
  input wire logic [2:0]        mc_upper_bit,
  input wire logic              mc_upper_value,
  input wire logic              mc_lower_prog,
  input wire logic              mc_lower_byte,
  input wire logic [2:0]        mc_lower_bit,
  input wire logic              mc_lower_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // Length of the current strobe; one extra cycle is allowed because the
  // strobe is cleared on the edge after the timer's done pulse.
  logic        any_s;
  logic        prog_s;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  assign prog_s  = mc_upper_prog | mc_lower_prog;
  assign any_s   = prog_s | mc_rd_en;
  assign nxt_cnt = any_s ? cnt_ff + 16'h1 : 16'h0;

  // Counter runs only while some strobe is high.
  always_ff @(posedge sys_clk) begin
    cnt_ff <= reset_n ? nxt_cnt : 16'h0;
  end

  a_strobe_excl: assert property (mc_rd_en |-> !prog_s)
    else $error("read and program strobes overlap");
  a_read_len: assert property ($fell(mc_rd_en) && $past(reset_n) |->
    (cnt_ff == RD_CYC || cnt_ff == RD_CYC + 1))
    else $error("read strobe length wrong");
  a_prog_normal: assert property ($fell(prog_s) && $past(reset_n)
    && !mc_fast |-> (cnt_ff == PROG_CYC || cnt_ff == PROG_CYC + 1))
    else $error("normal program strobe length wrong");
  a_prog_fast: assert property ($fell(prog_s) && $past(reset_n)
    && mc_fast |-> (cnt_ff == FAST_CYC || cnt_ff == FAST_CYC + 1))
    else $error("fast program strobe length wrong");
  a_addr_held: assert property (any_s && $past(any_s) |->
    $stable(mc_addr) && $stable(mc_fast))
    else $error("word address moved during strobe");
  a_upper_held: assert property (any_s && $past(any_s) |->
    $stable({mc_upper_byte, mc_upper_bit, mc_upper_value}))
    else $error("upper cell select moved during strobe");
  a_lower_held: assert property (any_s && $past(any_s) |->
    $stable({mc_lower_byte, mc_lower_bit, mc_lower_value}))
    else $error("lower cell select moved during strobe");
  a_reset_quiet: assert property ($rose(reset_n) |-> !any_s
    && !s_axi_bvalid && !s_axi_rvalid && mc_addr == '0)
    else $error("outputs not cleared by reset");
endmodule : otpbp_ctrl_asserts

bind otpbp_ctrl otpbp_ctrl_asserts #(
  .ADDR_W(ADDR_W), .PROG_CYC(PROG_CYC), .FAST_CYC(FAST_CYC),
  .RD_CYC(RD_CYC)
) i_otpbp_ctrl_asserts (
  .sys_clk(sys_clk), .reset_n(reset_n), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .mc_addr(mc_addr), .mc_rd_en(mc_rd_en),
  .mc_fast(mc_fast), .mc_upper_prog(mc_upper_prog),
  .mc_upper_byte(mc_upper_byte), .mc_upper_bit(mc_upper_bit),
  .mc_upper_value(mc_upper_value), .mc_lower_prog(mc_lower_prog),
  .mc_lower_byte(mc_lower_byte), .mc_lower_bit(mc_lower_bit),
  .mc_lower_value(mc_lower_value)
);
`default_nettype wire

/* File: testbench/otpbp_cells_model.sv */
// Behavioural model of the two 8-bit cell banks, 16 words deep.
// Assumes the controller holds fields steady for the whole strobe.
`timescale 1ns/1ps
`default_nettype none
module otpbp_cells_model (
  // Clock.
  input wire logic        sys_clk,
  // Strobes and fields from the controller.
  input wire logic [12:0] mc_addr,
  input wire logic        mc_rd_en,
  input wire logic        mc_upper_prog,
  input wire logic        mc_upper_byte,
  input wire logic [2:0]  mc_upper_bit,
  input wire logic        mc_upper_value,
  input wire logic        mc_lower_prog,
  input wire logic        mc_lower_byte,
  input wire logic [2:0]  mc_lower_bit,
  input wire logic        mc_lower_value,
  // Read data, {byte 1, byte 0} of each bank.
  output logic [15:0]     mc_upper_rdata,
  output logic [15:0]     mc_lower_rdata
);
  logic [15:0] up_mem [16];
  logic [15:0] lo_mem [16];
  logic [15:0] up_last;
  logic [15:0] lo_last;

  initial begin
    for (int i = 0; i < 16; i++) begin
      up_mem[i] = 16'h0;
      lo_mem[i] = 16'h0;
    end
    up_last = 16'h0;
    lo_last = 16'h0;
  end

  // A cell takes its value only while its own bank strobe is high.
  always @(posedge sys_clk) begin
    if (mc_upper_prog) begin
      up_mem[mc_addr[3:0]][{mc_upper_byte, mc_upper_bit}] <= mc_upper_value;
    end
    if (mc_lower_prog) begin
      lo_mem[mc_addr[3:0]][{mc_lower_byte, mc_lower_bit}] <= mc_lower_value;
    end
    if (mc_rd_en) begin
      up_last <= up_mem[mc_addr[3:0]];
      lo_last <= lo_mem[mc_addr[3:0]];
    end
  end

  // Outside a read the lines show the inverse, so stale data never matches.
  assign mc_upper_rdata = mc_rd_en ? up_mem[mc_addr[3:0]] : ~up_last;
  assign mc_lower_rdata = mc_rd_en ? lo_mem[mc_addr[3:0]] : ~lo_last;
endmodule : otpbp_cells_model
`default_nettype wire

/* File: testbench/otp_mode_and_bit_program_ctrl_bench.sv */
// Self-checking bench for otpbp_ctrl with a cell model on the far side.
// Assumes shortened strobe counts; expectations kept in a bench model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module otp_mode_and_bit_program_ctrl_bench;
  import otpbp_pkg::*;
  logic        sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, mc_rd_en, mc_fast;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, pc;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [12:0] mc_addr;
  logic        mc_upper_prog, mc_upper_byte, mc_upper_value;
  logic        mc_lower_prog, mc_lower_byte, mc_lower_value;
  logic [2:0]  mc_upper_bit, mc_lower_bit;
  logic [15:0] mc_upper_rdata, mc_lower_rdata;
  logic [15:0] up_m [16];
  logic [15:0] lo_m [16];
  int          failures, n_checks, cyc;

  otpbp_ctrl #(.ADDR_W(13), .TIMER_W(16), .PROG_CYC(4), .FAST_CYC(2),
    .RD_CYC(2)) i_otpbp_ctrl (.*);
  otpbp_cells_model i_otpbp_cells_model (.*);

  // Free-running clock and a cycle ceiling that cuts a hang short.
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Readiness is sampled at the falling edge, where it equals what the
  // next rising edge sees, so no race with the design's own updates.
  task automatic axi_wr(input logic [31:0] a, d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    aw = 1'b1; w = 1'b1; b = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!b) begin
      @(negedge sys_clk);
      b = s_axi_bvalid; r = s_axi_bresp;
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      @(posedge sys_clk);
      if (!aw) s_axi_awvalid <= 1'b0;
      if (!w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
    end
    @(posedge sys_clk);
    `CHK(r, er)
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, ed, input logic [1:0] er);
    logic ar, rv;
    logic [31:0] d;
    logic [1:0] r;
    ar = 1'b1; rv = 1'b0;
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!rv) begin
      @(negedge sys_clk);
      rv = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      if (s_axi_arready) ar = 1'b0;
      @(posedge sys_clk);
      if (!ar) s_axi_arvalid <= 1'b0;
      if (rv) s_axi_rready <= 1'b0;
    end
    @(posedge sys_clk);
    `CHK(d, ed)
    `CHK(r, er)
  endtask : axi_rd

  // Manual mode changes always pass through standby first.
  task automatic set_mode(input logic [2:0] m, input logic f);
    axi_wr(ADDR_MODE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_MODE, {23'h0, f, 5'h0, m}, RESP_OKAY);
  endtask : set_mode

  // The timer also runs with both banks off, so a margin follows.
  task automatic wait_idle();
    int t;
    t = 0;
    do begin
      @(negedge sys_clk);
      t++;
    end while ((mc_rd_en | mc_upper_prog | mc_lower_prog) && t < 50);
    repeat (8) @(posedge sys_clk);
  endtask : wait_idle

  task automatic model_prog(input logic [31:0] p);
    if (p[UEN_BIT]) up_m[p[3:0]][{p[USEL_BIT], p[22:20]}] = p[UVAL_BIT];
    if (p[LEN_BIT]) lo_m[p[3:0]][{p[LSEL_BIT], p[18:16]}] = p[LVAL_BIT];
  endtask : model_prog

  function automatic logic [31:0] word_of(input logic [3:0] w);
    return {up_m[w][15:8], lo_m[w][15:8], up_m[w][7:0], lo_m[w][7:0]};
  endfunction : word_of

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    s_axi_rready = 1'b0; s_axi_wstrb = 4'hf; reset_n = 1'b0;
    s_axi_awaddr = 32'h0; s_axi_wdata = 32'h0; s_axi_araddr = 32'h0;
    failures = 0; n_checks = 0; cyc = 0;
    for (int i = 0; i < 16; i++) begin
      up_m[i] = 16'h0;
      lo_m[i] = 16'h0;
    end
    void'($urandom(32'h4b72));
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    axi_rd(ADDR_MODE, MODE_RST, RESP_OKAY);
    axi_rd(ADDR_PCTRL, PCTRL_RST, RESP_OKAY);
    axi_rd(ADDR_STAT, 32'h2, RESP_OKAY);
    axi_rd(ADDR_RDWORD, RDWORD_RST, RESP_OKAY);
    axi_rd(32'h4000_8010, 32'h0, RESP_SLVERR);
    $display("test reset values done");
    // Reserved bits read zero; a pctrl write in standby launches nothing.
    axi_wr(ADDR_MODE, ~MODE_MASK, RESP_OKAY);
    axi_rd(ADDR_MODE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_PCTRL, 32'hffff_ffff, RESP_OKAY);
    @(negedge sys_clk);
    `CHK({mc_rd_en, mc_upper_prog, mc_lower_prog}, 3'h0)
    @(posedge sys_clk);
    axi_rd(ADDR_PCTRL, PCTRL_MASK, RESP_OKAY);
    axi_wr(32'h4000_8020, 32'h1, RESP_SLVERR);
    $display("test register masks done");
    // Manual programming, every bank-enable pair, both timings.
    for (int i = 0; i < 8; i++) begin
      set_mode(manual_program, i[0]);
      pc = $urandom & 32'h05ff_000f;
      pc[UEN_BIT] = i[2];
      pc[LEN_BIT] = i[1];
      axi_wr(ADDR_PCTRL, pc, RESP_OKAY);
      @(negedge sys_clk);
      `CHK(mc_upper_prog, pc[UEN_BIT])
      `CHK(mc_lower_prog, pc[LEN_BIT])
      `CHK(mc_addr, pc[12:0])
      `CHK(mc_fast, i[0])
      if (pc[UEN_BIT]) begin
        `CHK({mc_upper_byte, mc_upper_bit}, pc[23:20])
        `CHK(mc_upper_value, pc[UVAL_BIT])
      end
      if (pc[LEN_BIT]) begin
        `CHK({mc_lower_byte, mc_lower_bit}, pc[19:16])
        `CHK(mc_lower_value, pc[LVAL_BIT])
      end
      model_prog(pc);
      wait_idle();
    end
    $display("test manual program done");
    set_mode(manual_read, 1'b0);
    for (int w = 0; w < 16; w++) begin
      axi_wr(ADDR_PCTRL, w, RESP_OKAY);
      wait_idle();
      axi_rd(ADDR_RDWORD, word_of(w), RESP_OKAY);
    end
    $display("test manual read done");
    // Automatic program shows busy, then automatic read returns the word.
    pc = ($urandom & 32'h05ff_000f) | 32'h0a00_0000;
    axi_wr(ADDR_MODE, 32'h0, RESP_OKAY);
    axi_wr(ADDR_PCTRL, pc, RESP_OKAY);
    axi_wr(ADDR_MODE, {29'h0, auto_program}, RESP_OKAY);
    axi_rd(ADDR_STAT, 32'h0, RESP_OKAY);
    model_prog(pc);
    wait_idle();
    axi_rd(ADDR_STAT, 32'h2, RESP_OKAY);
    set_mode(auto_read, 1'b0);
    wait_idle();
    axi_rd(ADDR_RDWORD, word_of(pc[3:0]), RESP_OKAY);
    $display("test automatic modes done");
    print_verdict();
  end
endmodule : otp_mode_and_bit_program_ctrl_bench
`default_nettype wire
